// >>> rtl/ohcirb_top.v
// Host controller register bank: interrupt enable set and clear pair,
// communication area base, periodic cursor and control list head.
// Assumes an APB master on pclk; the list engine drives the cursor and
// event pulses synchronously to pclk.
`timescale 1ns/1ps
`include "ohcirb_defs.vh"

module ohcirb_top #(
    parameter NSRC = `OHCIRB_SRC_W
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [NSRC-1:0] src_event,
    input wire cursor_load,
    input wire [31:0] cursor_addr,
    input wire [NSRC-1:0] line_req,
    output wire irq
);

    // Register state and the next values that the clocked processes load.
    // Every register is a plain flop behind a combinational next value.
    reg [NSRC-1:0] irq_status;
    reg [`OHCIRB_BASE_W-1:0] host_comm_area_base;
    reg [`OHCIRB_BASE_W-1:0] next_host_comm_area_base;
    reg [`OHCIRB_PTR_W-1:0] periodic_list_cursor;
    reg [`OHCIRB_PTR_W-1:0] next_periodic_list_cursor;
    reg [`OHCIRB_PTR_W-1:0] control_list_head;
    reg [`OHCIRB_PTR_W-1:0] next_control_list_head;
    reg master_irq_enable;
    reg next_master_irq_enable;
    reg [`OHCIRB_WORD_MSB:0] next_rdata;
    wire [NSRC-1:0] next_irq_status;

    // Source enables, synchronised requests and per-bit strobes.
    wire [NSRC-1:0] src_enable;
    wire [NSRC-1:0] line_sync;
    wire [NSRC-1:0] en_set;
    wire [NSRC-1:0] en_clr;
    wire [NSRC-1:0] status_set;
    wire [NSRC-1:0] status_clr;
    wire [NSRC-1:0] src_pending;

    // Bus phase qualifiers and register selects.
    wire access;
    wire wr;
    wire rd_setup;
    wire hit;
    wire sel_status;
    wire sel_enable;
    wire sel_enable_clear;
    wire sel_comm_base;
    wire sel_cursor;
    wire sel_head;
    wire wr_status;
    wire wr_enable;
    wire wr_enable_clear;
    wire wr_comm_base;
    wire wr_head;

    // Read words, each already zero in its reserved positions.
    wire [`OHCIRB_WORD_MSB:0] status_word;
    wire [`OHCIRB_WORD_MSB:0] enable_word;
    wire [`OHCIRB_WORD_MSB:0] comm_base_word;
    wire [`OHCIRB_WORD_MSB:0] cursor_word;
    wire [`OHCIRB_WORD_MSB:0] head_word;

    ////////////////////////////////////////////////////////////////////////
    // APB phases. The bank answers in the first access cycle, so every
    // transfer takes exactly two cycles and pready never drops.
    // A wait state would only need pready driven low; nothing else moves.
    assign access = psel & penable;
    assign wr = access & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready = 1'b1;

    // Address decode; one select per register of the map.
    assign sel_status = (paddr == `OHCIRB_OFF_IRQ_STATUS);
    assign sel_enable = (paddr == `OHCIRB_OFF_IRQ_ENABLE);
    assign sel_enable_clear = (paddr == `OHCIRB_OFF_IRQ_ENABLE_CLEAR);
    assign sel_comm_base = (paddr == `OHCIRB_OFF_COMM_AREA_BASE);
    assign sel_cursor = (paddr == `OHCIRB_OFF_PERIODIC_CURSOR);
    assign sel_head = (paddr == `OHCIRB_OFF_CONTROL_LIST_HEAD);
    assign hit = sel_status | sel_enable | sel_enable_clear |
                 sel_comm_base | sel_cursor | sel_head;

    // An unmapped offset is flagged in the access phase only, so that a
    // master sampling pslverr with pready sees it and nothing earlier.
    assign pslverr = access & ~hit;

    // Write strobes. The cursor has none: software cannot move it.
    assign wr_status = wr & sel_status;
    assign wr_enable = wr & sel_enable;
    assign wr_enable_clear = wr & sel_enable_clear;
    assign wr_comm_base = wr & sel_comm_base;
    assign wr_head = wr & sel_head;

    ////////////////////////////////////////////////////////////////////////
    // Source enable strobes. A one in the enable register sets a bit, a
    // one in the clear register drops it, and zeros leave bits alone.
    // The ownership change position has no strobe and always reads zero.
    assign en_set = wr_enable ? pwdata[NSRC-1:0] : {NSRC{1'b0}};
    assign en_clr = wr_enable_clear ? pwdata[NSRC-1:0] : {NSRC{1'b0}};

    ohcirb_enable_bits #(
        .N(NSRC)
    ) u_en (
        .pclk(pclk),
        .presetn(presetn),
        .set_mask(en_set),
        .clr_mask(en_clr),
        .enable(src_enable)
    );

    // External level requests come from another domain, so they are
    // synchronised before they can set a status bit.
    // A request shorter than two clocks may be missed.
    ohcirb_sync2 #(
        .W(NSRC)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(line_req),
        .q(line_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // Master enable. Both writes of a one name bit 31, but they reach
    // different registers, so set and clear never meet in one cycle.
    always @* begin
        next_master_irq_enable = master_irq_enable;
        if (wr_enable && pwdata[`OHCIRB_MASTER_BIT]) begin
            next_master_irq_enable = 1'b1;
        end else if (wr_enable_clear && pwdata[`OHCIRB_MASTER_BIT]) begin
            next_master_irq_enable = 1'b0;
        end
    end

    // The master enable flop. A reset leaves every interrupt masked, so
    // software meets a quiet line until it has set up its handler.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            master_irq_enable <= 1'b0;
        end else begin
            master_irq_enable <= next_master_irq_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky event status, one bit per source. Events from the list
    // engine and synchronised line requests both set a bit; a one written
    // to the status register clears it. A new event in the cycle of its
    // clear wins, since losing an event would hide it from software for
    // good, while a stale bit costs only one more interrupt.
    genvar i;
    generate
        for (i = 0; i < NSRC; i = i + 1) begin : g_status
            assign status_set[i] = src_event[i] | line_sync[i];
            assign status_clr[i] = wr_status & pwdata[i];
            assign next_irq_status[i] = status_set[i] |
                                        (irq_status[i] & ~status_clr[i]);
            assign src_pending[i] = irq_status[i] & src_enable[i];
        end
    endgenerate

    // The status flops. Status records events whether or not they are
    // enabled, so software can poll with the line masked.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= `OHCIRB_SRC_RST;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // The line is a level: a pending source counts only while the master
    // enable is set as well.
    assign irq = master_irq_enable & (|src_pending);

    ////////////////////////////////////////////////////////////////////////
    // Pointer registers. Only the address fields are stored, so reserved
    // low bits cannot hold anything that a write puts there; the price is
    // that software cannot use them as scratch bits.
    always @* begin
        next_host_comm_area_base = host_comm_area_base;
        if (wr_comm_base) begin
            next_host_comm_area_base =
                pwdata[`OHCIRB_WORD_MSB:`OHCIRB_BASE_LSB];
        end
    end

    // Control list head; descriptors sit on 16-byte boundaries, so the
    // four low address bits are never kept.
    always @* begin
        next_control_list_head = control_list_head;
        if (wr_head) begin
            next_control_list_head =
                pwdata[`OHCIRB_WORD_MSB:`OHCIRB_PTR_LSB];
        end
    end

    // The cursor is loaded by the list engine only; bus writes are
    // ignored because the register is read-only to software.
    always @* begin
        next_periodic_list_cursor = periodic_list_cursor;
        if (cursor_load) begin
            next_periodic_list_cursor =
                cursor_addr[`OHCIRB_WORD_MSB:`OHCIRB_PTR_LSB];
        end
    end

    // Pointer flops, all zero after reset. A zero pointer is safe: the
    // list engine treats it as an empty list.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_comm_area_base <= `OHCIRB_BASE_RST;
            control_list_head <= `OHCIRB_PTR_RST;
            periodic_list_cursor <= `OHCIRB_PTR_RST;
        end else begin
            host_comm_area_base <= next_host_comm_area_base;
            control_list_head <= next_control_list_head;
            periodic_list_cursor <= next_periodic_list_cursor;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read words. Reserved positions are tied to zero here.
    // Status shows the raw events, masked or not.
    assign status_word = {{(`OHCIRB_WORD_W - NSRC){1'b0}}, irq_status};

    // The enable word keeps the ownership change position at zero.
    assign enable_word = {master_irq_enable,
                          {(`OHCIRB_WORD_W - 1 - NSRC){1'b0}},
                          src_enable};

    // Pointer words put the stored field back at its address position.
    assign comm_base_word = {host_comm_area_base,
                             {`OHCIRB_BASE_LSB{1'b0}}};
    assign cursor_word = {periodic_list_cursor,
                          {`OHCIRB_PTR_LSB{1'b0}}};
    assign head_word = {control_list_head,
                        {`OHCIRB_PTR_LSB{1'b0}}};

    // Read mux. The clear register reads as zero in every bit, as does
    // any unmapped offset, so a stray read never leaks an old value.
    // The mux follows paddr alone; the flop below decides when to take it.
    always @* begin
        next_rdata = `OHCIRB_ZERO32;
        case (paddr)
            `OHCIRB_OFF_IRQ_STATUS: begin
                next_rdata = status_word;
            end
            `OHCIRB_OFF_IRQ_ENABLE: begin
                next_rdata = enable_word;
            end
            `OHCIRB_OFF_IRQ_ENABLE_CLEAR: begin
                next_rdata = `OHCIRB_ZERO32;
            end
            `OHCIRB_OFF_COMM_AREA_BASE: begin
                next_rdata = comm_base_word;
            end
            `OHCIRB_OFF_PERIODIC_CURSOR: begin
                next_rdata = cursor_word;
            end
            `OHCIRB_OFF_CONTROL_LIST_HEAD: begin
                next_rdata = head_word;
            end
            default: begin
                next_rdata = `OHCIRB_ZERO32;
            end
        endcase
    end

    // Read data is registered in the setup cycle, so it comes from a flop
    // and is stable for the whole access cycle. It then holds until the
    // next read, which keeps the bus quiet between transfers.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `OHCIRB_ZERO32;
        end else if (rd_setup) begin
            prdata <= next_rdata;
        end
    end

endmodule

// >>> rtl/ohcirb_defs.vh
// Register map, field layouts and reset values of the register bank.
// Assumes inclusion by bare name from the design files.
`ifndef OHCIRB_DEFS_VH
`define OHCIRB_DEFS_VH

// Word offsets of the registers (byte addresses on the APB).
`define OHCIRB_OFF_IRQ_STATUS 8'h0C
`define OHCIRB_OFF_IRQ_ENABLE 8'h10
`define OHCIRB_OFF_IRQ_ENABLE_CLEAR 8'h14
`define OHCIRB_OFF_COMM_AREA_BASE 8'h18
`define OHCIRB_OFF_PERIODIC_CURSOR 8'h1C
`define OHCIRB_OFF_CONTROL_LIST_HEAD 8'h20

// Field positions and widths.
`define OHCIRB_WORD_W 32
`define OHCIRB_WORD_MSB 31
`define OHCIRB_MASTER_BIT 31
`define OHCIRB_SRC_W 7
`define OHCIRB_BASE_LSB 8
`define OHCIRB_BASE_W 24
`define OHCIRB_PTR_LSB 4
`define OHCIRB_PTR_W 28

// Reset values.
`define OHCIRB_SRC_RST 7'h00
`define OHCIRB_BASE_RST 24'h000000
`define OHCIRB_PTR_RST 28'h0000000
`define OHCIRB_ZERO32 32'h00000000

`endif

// >>> rtl/ohcirb_enable_bits.v
// Interrupt enable bits: set by a write of one, cleared by a write of one
// to the companion clear register. Assumes one clock and an async reset.
`timescale 1ns/1ps
`include "ohcirb_defs.vh"

module ohcirb_enable_bits #(
    parameter N = 7
) (
    input wire pclk,
    input wire presetn,
    input wire [N-1:0] set_mask,
    input wire [N-1:0] clr_mask,
    output reg [N-1:0] enable
);

    ////////////////////////////////////////////////////////////////////////
    // One flop per enable; a bit written in both registers at once cannot
    // happen since a single APB write reaches only one register.
    genvar i;
    generate
        for (i = 0; i < N; i = i + 1) begin : g_en
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    enable[i] <= 1'b0;
                end else if (set_mask[i]) begin
                    enable[i] <= 1'b1;
                end else if (clr_mask[i]) begin
                    enable[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule

// >>> rtl/ohcirb_sync2.v
// Two-flop synchroniser for levels arriving from outside pclk.
// Assumes the input is a slow level, not a pulse shorter than two clocks.
`timescale 1ns/1ps

module ohcirb_sync2 #(
    parameter W = 1
) (
    input wire pclk,
    input wire presetn,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);

    reg [W-1:0] meta;

    ////////////////////////////////////////////////////////////////////////
    // The first stage is read by the second stage only.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta <= d;
            q <= meta;
        end
    end

endmodule

// >>> test/ohcirb_chk.sv
// Checker for the register bank ports.
// Assumes zero wait state APB and read data loaded at the setup edge.
`timescale 1ns/1ps
module ohcirb_chk #(
    parameter NSRC = 7
) (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic pready,
    input logic pslverr,
    input logic [NSRC-1:0] src_event,
    input logic cursor_load,
    input logic [31:0] cursor_addr,
    input logic [NSRC-1:0] line_req,
    input logic irq
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
logic rd_acc;
logic wr_acc;
// Access phase qualifiers, shared by the properties below save chk_unmapped_err and the last two covers.
assign rd_acc = psel && penable && !pwrite;
assign wr_acc = psel && penable && pwrite;
////////////////////////////////////////////////////////////////////////
chk_clr_reads_zero: assert property (
    rd_acc && paddr == 8'h14 |-> prdata == 32'h0)
    else $error("clear register read not zero");
chk_base_low_zero: assert property (
    rd_acc && paddr == 8'h18 |-> prdata[7:0] == 8'h0)
    else $error("base low byte not zero");
chk_ptr_low_zero: assert property (
    rd_acc && paddr inside {8'h1C, 8'h20} |-> prdata[3:0] == 4'h0)
    else $error("pointer low bits not zero");
chk_enable_reserved: assert property (
    rd_acc && paddr == 8'h10 |-> prdata[29:7] == 23'h0)
    else $error("enable reserved bits set");
chk_status_reserved: assert property (
    rd_acc && paddr == 8'h0C |-> prdata[31:7] == 25'h0)
    else $error("status reserved bits set");
chk_master_clear: assert property (
    wr_acc && paddr == 8'h14 && pwdata[31] |=> !irq)
    else $error("master clear left irq high");
chk_sources_clear: assert property (
    wr_acc && paddr == 8'h14 && pwdata[6:0] == 7'h7F |=> !irq)
    else $error("source clear left irq high");
chk_irq_cause: assert property (
    $rose(irq) |-> $past(wr_acc && paddr == 8'h10) || $past(|src_event) ||
    $past(|line_req, 3))
    else $error("irq rose without enable or event");
chk_unmapped_err: assert property (
    psel && penable &&
    !(paddr inside {8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20}) |-> pslverr)
    else $error("unmapped access without pslverr");
// Main scenarios seen at least once.
cover property (wr_acc && paddr == 8'h14 && pwdata[31]);
cover property ($rose(irq));
cover property (cursor_load);
endmodule
bind ohcirb_top ohcirb_chk #(.NSRC(NSRC)) u_chk (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .src_event, .cursor_load, .cursor_addr, .line_req, .irq);

// >>> test/tb.sv
// Self-checking bench for the register bank, driven as an APB master.
// Assumes the bank may stall on pready; the watchdog cuts any hang.
`timescale 1ns/1ps
module tb;
logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
logic cursor_load = 0, err, pready, pslverr, irq;
logic [7:0] paddr = 8'h0;
logic [31:0] pwdata = 32'h0, cursor_addr = 32'h0, prdata, rdata;
logic [6:0] src_event = 7'h0, line_req = 7'h0;
int mismatches = 0, comparisons = 0;
ohcirb_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .src_event, .cursor_load,
    .cursor_addr, .line_req, .irq);
// Clock of 8 ns.
always #4 pclk = ~pclk;
////////////////////////////////////////////////////////////////////////
task cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
        mismatches++;
        $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
endtask
// One APB transfer; ends at a falling edge so results have settled.
task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    err = pslverr;
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
endtask
task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    cmp(rdata, e);
endtask
task pulse(input logic [6:0] m);
    @(posedge pclk);
    src_event <= m;
    @(posedge pclk);
    src_event <= 7'h0;
    @(negedge pclk);
endtask
task give_verdict;
    if (mismatches == 0 && comparisons > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////
// Main sequence: reset values, enable pair, interrupts, pointers.
initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 3; i < 9; i++) rd(8'(i * 4), 32'h0);
    xfer(1'b1, 8'h10, 32'hFFFFFFFF);
    rd(8'h10, 32'h8000007F);
    rd(8'h14, 32'h0);
    xfer(1'b1, 8'h14, 32'h0);
    rd(8'h10, 32'h8000007F);
    xfer(1'b1, 8'h14, 32'hFFFFFFFF);
    rd(8'h10, 32'h0);
    // A request seen while masked must not raise the line.
    @(posedge pclk);
    line_req <= 7'h20;
    repeat (4) @(posedge pclk);
    line_req <= 7'h0;
    rd(8'h0C, 32'h20);
    cmp(irq, 32'h0);
    xfer(1'b1, 8'h10, 32'h20);
    cmp(irq, 32'h0);
    xfer(1'b1, 8'h10, 32'h80000000);
    cmp(irq, 32'h1);
    xfer(1'b1, 8'h14, 32'h80000000);
    cmp(irq, 32'h0);
    xfer(1'b1, 8'h0C, 32'h20);
    // Every source in turn: enable, fire, clear its enable.
    for (int i = 0; i < 7; i++) begin
        xfer(1'b1, 8'h10, 32'h80000000 | (32'h1 << i));
        pulse(7'(1 << i));
        cmp(irq, 32'h1);
        xfer(1'b1, 8'h14, 32'h1 << i);
        cmp(irq, 32'h0);
        xfer(1'b1, 8'h0C, 32'h1 << i);
        xfer(1'b1, 8'h14, 32'h80000000);
    end
    xfer(1'b1, 8'h18, 32'hFFFFFFFF);
    rd(8'h18, 32'hFFFFFF00);
    xfer(1'b1, 8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'hFFFFFFF0);
    @(posedge pclk);
    cursor_addr <= 32'h1234567F;
    cursor_load <= 1'b1;
    @(posedge pclk);
    cursor_load <= 1'b0;
    rd(8'h1C, 32'h12345670);
    xfer(1'b1, 8'h1C, 32'h0);
    cmp(err, 32'h0);
    rd(8'h1C, 32'h12345670);
    rd(8'h24, 32'h0);
    cmp(err, 32'h1);
    give_verdict;
end
// The sequence needs well under 1000 cycles; 2500 means a hang.
initial begin
    #20000;
    mismatches++;
    give_verdict;
end
endmodule
